// ==== src/ccr_defs.svh ====
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// register pointer values
`define CCR_ADDR_FIXED  8'h00
`define CCR_ADDR_CTRL   8'h01
`define CCR_ADDR_VF     8'h02
`define CCR_ADDR_IPK    8'h03

// output_control_config bit positions
`define CCR_BIT_EN      7
`define CCR_BIT_RAMP    6
`define CCR_BIT_FAST    5
`define CCR_BIT_ZC      4
`define CCR_BIT_EMI     3
`define CCR_BIT_BUCK    2
`define CCR_BIT_ACT     1
`define CCR_BIT_PSV     0

// reset values per variant
`define CCR_CTRL_RST_A  8'hf0
`define CCR_CTRL_RST_B  8'hd1
`define CCR_CTRL_RST_C  8'h51
`define CCR_VF_RST_A    8'he8
`define CCR_VF_RST_BC   8'hea
`define CCR_IPK_RST_AC  8'ha8
`define CCR_IPK_RST_B   8'h68

// timing: clock 250 MHz, ramp step 50 us
`define CCR_CLK_HZ        64'hee6b280
`define CCR_CLK_PERIOD_NS 32'h4
`define CCR_RAMP_STEP_NS  32'hc350
`define CCR_RAMP_CYC      (`CCR_RAMP_STEP_NS / `CCR_CLK_PERIOD_NS)
`define CCR_MILLI         64'h3e8
`define CCR_PER_CYC(mhz)  ((`CCR_CLK_HZ * `CCR_MILLI) / (mhz))

// frequency thresholds in millihertz
`define CCR_RISE0_MHZ   64'h17d7840
`define CCR_RISE1_MHZ   64'h2160ec0
`define CCR_RISE2_MHZ   64'h2faf080
`define CCR_RISE3_MHZ   64'h5f5e100
`define CCR_FALL0_MHZ   64'h5d75c8
`define CCR_FALL1_MHZ   64'h7de290
`define CCR_FALL2_MHZ   64'hbebc20
`define CCR_FALL3_MHZ   64'h17d7840

// voltage and current scales
`define CCR_VOUT_BASE_MV 13'h9c4
`define CCR_VOUT_STEP_MV 13'h032
`define CCR_VOUT_TOP_MV  13'h12c0
`define CCR_OUTPUT_VOLTAGE_CODE_SAT     6'h2e
`define CCR_IPK_STEP_MA  10'h032
`define CCR_IPK_HALF_MA  10'h019
`define CCR_IPK_TOP_MA   10'h2ee
`define CCR_IPK_TOPH_MA  10'h177
`define CCR_IPK_TOP_CODE 4'hf
`define CCR_PER_MAX      17'h1ffff

`endif

// ==== src/ccr_pkg.sv ====
package ccr_pkg;

    typedef enum logic [1:0] {
        CCR_VAR_A = 2'b00,
        CCR_VAR_B = 2'b01,
        CCR_VAR_C = 2'b10
    } ccr_variant_e;

    typedef struct packed {
        logic       addr_load;
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } ccr_req_s;

    typedef struct packed {
        logic        output_enable;
        logic        voltage_ramp_select;
        logic        fast_response;
        logic        zero_cross_comparator_off;
        logic        slow_edge_select;
        logic        buck_only;
        logic        active_discharge_select;
        logic        passive_discharge_select;
        logic [1:0]  freq_threshold_select;
        logic        keep_blocks_on;
        logic [5:0]  output_voltage_code;
        logic [12:0] output_voltage_mv;
        logic [3:0]  peak_current_code_high;
        logic [9:0]  peak_current_high_ma;
        logic [3:0]  peak_current_code_low;
        logic [9:0]  peak_current_low_ma;
    } ccr_cfg_s;

endpackage

// ==== src/ccr_regs.sv ====
`timescale 1ns/1ps
`include "ccr_defs.svh"

module ccr_regs
    import ccr_pkg::*;
#(
    parameter ccr_variant_e     VARIANT       = CCR_VAR_A,
    parameter logic [13:0]      RAMP_STEP_CYC = 14'(`CCR_RAMP_CYC),
    parameter logic [3:0][16:0] RISE_CYC      = {17'(`CCR_PER_CYC(`CCR_RISE3_MHZ)),
                                                 17'(`CCR_PER_CYC(`CCR_RISE2_MHZ)),
                                                 17'(`CCR_PER_CYC(`CCR_RISE1_MHZ)),
                                                 17'(`CCR_PER_CYC(`CCR_RISE0_MHZ))},
    parameter logic [3:0][16:0] FALL_CYC      = {17'(`CCR_PER_CYC(`CCR_FALL3_MHZ)),
                                                 17'(`CCR_PER_CYC(`CCR_FALL2_MHZ)),
                                                 17'(`CCR_PER_CYC(`CCR_FALL1_MHZ)),
                                                 17'(`CCR_PER_CYC(`CCR_FALL0_MHZ))}
)(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // byte access from the serial engine
    input  wire ccr_req_s   req,
    output logic            addr_ok_r,
    output logic [7:0]      rdata_r,
    // converter side
    input  wire logic       switch_size_halving,
    input  wire logic       sw_pulse_pin,
    output ccr_cfg_s        cfg_r
);

    function automatic logic [7:0] rst_val(input ccr_variant_e v, input logic [7:0] a);
        rst_val = 8'h00;
        case (a)
            `CCR_ADDR_CTRL: rst_val = (v == CCR_VAR_A) ? `CCR_CTRL_RST_A :
                                      (v == CCR_VAR_B) ? `CCR_CTRL_RST_B : `CCR_CTRL_RST_C;
            `CCR_ADDR_VF:   rst_val = (v == CCR_VAR_A) ? `CCR_VF_RST_A : `CCR_VF_RST_BC;
            `CCR_ADDR_IPK:  rst_val = (v == CCR_VAR_B) ? `CCR_IPK_RST_B : `CCR_IPK_RST_AC;
            default:        rst_val = 8'h00;
        endcase
    endfunction

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == `CCR_ADDR_CTRL) || (a == `CCR_ADDR_VF) || (a == `CCR_ADDR_IPK);
    endfunction

    function automatic logic [5:0] vsat(input logic [5:0] c);
        vsat = (c > `CCR_OUTPUT_VOLTAGE_CODE_SAT) ? `CCR_OUTPUT_VOLTAGE_CODE_SAT : c;
    endfunction

    function automatic logic [12:0] vout_mv(input logic [5:0] c);
        vout_mv = `CCR_VOUT_BASE_MV + 13'(vsat(c)) * `CCR_VOUT_STEP_MV;
    endfunction

    function automatic logic [9:0] ipk_ma(input logic [3:0] c, input logic low, input logic halve);
        if (c == 4'h0) begin
            ipk_ma = 10'h000;
        end else if (low && c == `CCR_IPK_TOP_CODE) begin
            ipk_ma = halve ? `CCR_IPK_TOPH_MA : `CCR_IPK_TOP_MA;
        end else begin
            ipk_ma = 10'(c) * (halve ? `CCR_IPK_HALF_MA : `CCR_IPK_STEP_MA);
        end
    endfunction

    localparam logic [7:0] CTRL_RST = rst_val(VARIANT, `CCR_ADDR_CTRL);
    localparam logic [7:0] VF_RST   = rst_val(VARIANT, `CCR_ADDR_VF);
    localparam logic [7:0] IPK_RST  = rst_val(VARIANT, `CCR_ADDR_IPK);

    logic [7:0]  ctrl_r;
    logic [7:0]  vf_r;
    logic [7:0]  ipk_r;
    logic [7:0]  ptr_r;
    logic        latch_zc_r;
    logic        latch_buck_r;
    logic [5:0]  vcode_r;
    logic [13:0] step_cnt_r;
    logic        step_tick_r;
    logic [2:0]  sw_sync_r;
    logic [16:0] per_cnt_r;
    logic        keep_on_r;
    logic        sw_edge;
    logic        ramp_up;

    assign sw_edge = sw_sync_r[1] & ~sw_sync_r[2];
    assign ramp_up = ctrl_r[`CCR_BIT_RAMP] && (vsat(vf_r[5:0]) > vsat(vcode_r));

    // register writes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_r <= CTRL_RST;
            vf_r   <= VF_RST;
            ipk_r  <= IPK_RST;
        end else if (req.wr && !req.addr_load) begin
            case (ptr_r)
                `CCR_ADDR_CTRL: ctrl_r <= req.wdata;
                `CCR_ADDR_VF:   vf_r   <= req.wdata;
                `CCR_ADDR_IPK:  ipk_r  <= req.wdata;
                default:        ;
            endcase
        end
    end

    // register pointer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ptr_r <= `CCR_ADDR_FIXED;
        end else if (req.addr_load) begin
            ptr_r <= req.addr;
        end else if ((req.wr || req.rd) && ptr_r != `CCR_ADDR_FIXED) begin
            ptr_r <= ptr_r + 8'h01;
        end
    end

    // read data and address acknowledge
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_r   <= 8'h00;
            addr_ok_r <= 1'b0;
        end else begin
            addr_ok_r <= addr_hit(ptr_r);
            case (ptr_r)
                `CCR_ADDR_CTRL: rdata_r <= ctrl_r;
                `CCR_ADDR_VF:   rdata_r <= vf_r;
                `CCR_ADDR_IPK:  rdata_r <= ipk_r;
                default:        rdata_r <= 8'h00;
            endcase
        end
    end

    // internal latches follow the register only while disabled
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            latch_zc_r   <= CTRL_RST[`CCR_BIT_ZC];
            latch_buck_r <= CTRL_RST[`CCR_BIT_BUCK];
        end else if (!ctrl_r[`CCR_BIT_EN]) begin
            latch_zc_r   <= ctrl_r[`CCR_BIT_ZC];
            latch_buck_r <= ctrl_r[`CCR_BIT_BUCK];
        end
    end

    // ramp step divider
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            step_cnt_r  <= 14'h0000;
            step_tick_r <= 1'b0;
        end else if (step_cnt_r >= RAMP_STEP_CYC - 14'h0001) begin
            step_cnt_r  <= 14'h0000;
            step_tick_r <= 1'b1;
        end else begin
            step_cnt_r  <= step_cnt_r + 14'h0001;
            step_tick_r <= 1'b0;
        end
    end

    // applied voltage code
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            vcode_r <= VF_RST[5:0];
        end else if (ramp_up) begin
            if (step_tick_r) begin
                vcode_r <= vcode_r + 6'h01;
            end
        end else begin
            vcode_r <= vf_r[5:0];
        end
    end

    // switching pulse synchroniser
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sw_sync_r <= 3'h0;
        end else begin
            sw_sync_r <= {sw_sync_r[1:0], sw_pulse_pin};
        end
    end

    // switching period and keep-on hysteresis
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            per_cnt_r <= `CCR_PER_MAX;
            keep_on_r <= 1'b0;
        end else begin
            if (sw_edge) begin
                per_cnt_r <= 17'h00001;
            end else if (per_cnt_r != `CCR_PER_MAX) begin
                per_cnt_r <= per_cnt_r + 17'h00001;
            end
            if (sw_edge && per_cnt_r < RISE_CYC[vf_r[7:6]]) begin
                keep_on_r <= 1'b1;
            end else if (per_cnt_r >= FALL_CYC[vf_r[7:6]]) begin
                keep_on_r <= 1'b0;
            end
        end
    end

    // registered configuration outputs
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_r <= '0;
        end else begin
            cfg_r.output_enable             <= ctrl_r[`CCR_BIT_EN];
            cfg_r.voltage_ramp_select       <= ctrl_r[`CCR_BIT_RAMP];
            cfg_r.fast_response             <= ctrl_r[`CCR_BIT_FAST];
            cfg_r.zero_cross_comparator_off <= latch_zc_r;
            cfg_r.slow_edge_select          <= ctrl_r[`CCR_BIT_EMI];
            cfg_r.buck_only                 <= latch_buck_r;
            cfg_r.active_discharge_select   <= ctrl_r[`CCR_BIT_ACT];
            cfg_r.passive_discharge_select  <= ctrl_r[`CCR_BIT_PSV];
            cfg_r.freq_threshold_select     <= vf_r[7:6];
            cfg_r.keep_blocks_on            <= keep_on_r;
            cfg_r.output_voltage_code       <= vcode_r;
            cfg_r.output_voltage_mv         <= vout_mv(vcode_r);
            cfg_r.peak_current_code_high    <= ipk_r[7:4];
            cfg_r.peak_current_high_ma      <= ipk_ma(ipk_r[7:4], 1'b0, switch_size_halving);
            cfg_r.peak_current_code_low     <= ipk_r[3:0];
            cfg_r.peak_current_low_ma       <= ipk_ma(ipk_r[3:0], 1'b1, switch_size_halving);
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    enable_follow_a: assert property ($past(!sys_rst) |-> cfg_r.output_enable == $past(ctrl_r[`CCR_BIT_EN]))
        else $error("output enable does not follow control bit");
    ramp_wait_a: assert property (ramp_up && !step_tick_r |=> vcode_r == $past(vcode_r))
        else $error("ramp moved without a step tick");
    ramp_step_a: assert property (ramp_up && step_tick_r |=> vcode_r == $past(vcode_r) + 6'h01)
        else $error("ramp step is not one code");
    ramp_off_a: assert property (!ctrl_r[`CCR_BIT_RAMP] |=> vcode_r == $past(vf_r[5:0]))
        else $error("target not applied at once");
    zc_hold_a: assert property (ctrl_r[`CCR_BIT_EN] |=> latch_zc_r == $past(latch_zc_r))
        else $error("comparator latch changed while enabled");
    buck_latch_a: assert property (ctrl_r[`CCR_BIT_EN] |=> $stable(latch_buck_r))
        else $error("buck-only latch changed while enabled");
    latch_copy_a: assert property (!ctrl_r[`CCR_BIT_EN] |=> latch_buck_r == $past(ctrl_r[`CCR_BIT_BUCK]))
        else $error("latch did not copy while disabled");
    keep_rise_a: assert property ($rose(keep_on_r)
                                  |-> $past(sw_edge) && $past(per_cnt_r) < $past(RISE_CYC[vf_r[7:6]]))
        else $error("blocks kept on without fast switching");
    keep_fall_a: assert property ($fell(keep_on_r) |-> $past(per_cnt_r) >= $past(FALL_CYC[vf_r[7:6]]))
        else $error("blocks released above falling threshold");
    vout_top_a: assert property (vcode_r > `CCR_OUTPUT_VOLTAGE_CODE_SAT |=> cfg_r.output_voltage_mv == `CCR_VOUT_TOP_MV)
        else $error("saturated code not at top voltage");
    ipk_zero_a: assert property (ipk_r[7:4] == 4'h0 |=> cfg_r.peak_current_high_ma == 10'h000)
        else $error("code zero not minimum on-time");
    ipk_top_a: assert property (ipk_r[3:0] == `CCR_IPK_TOP_CODE && !switch_size_halving
                                |=> cfg_r.peak_current_low_ma == `CCR_IPK_TOP_MA)
        else $error("low code fifteen not top current");
    ptr_hold_a: assert property (req.wr && !req.addr_load && ptr_r == `CCR_ADDR_FIXED
                                 |=> ptr_r == `CCR_ADDR_FIXED)
        else $error("pointer moved at fixed address");
    ptr_step_a: assert property (req.wr && !req.addr_load && ptr_r != `CCR_ADDR_FIXED
                                 |=> ptr_r == $past(ptr_r) + 8'h01)
        else $error("pointer did not advance");
    ptr_load_a: assert property (req.addr_load |=> ptr_r == $past(req.addr))
        else $error("pointer not loaded from address");

    // plain outputs trail their register bits by one cycle
    fast_follow_a: assert property ($past(!sys_rst) |-> cfg_r.fast_response == $past(ctrl_r[`CCR_BIT_FAST]))
        else $error("fast response does not follow control bit");
    slow_follow_a: assert property ($past(!sys_rst) |-> cfg_r.slow_edge_select == $past(ctrl_r[`CCR_BIT_EMI]))
        else $error("slow edge does not follow control bit");
    act_follow_a: assert property ($past(!sys_rst)
                                   |-> cfg_r.active_discharge_select == $past(ctrl_r[`CCR_BIT_ACT]))
        else $error("active discharge does not follow control bit");
    psv_follow_a: assert property ($past(!sys_rst)
                                   |-> cfg_r.passive_discharge_select == $past(ctrl_r[`CCR_BIT_PSV]))
        else $error("passive discharge does not follow control bit");
    fsel_follow_a: assert property ($past(!sys_rst) |-> cfg_r.freq_threshold_select == $past(vf_r[7:6]))
        else $error("threshold select does not follow register");

    // latched fields reach the outputs only through the latch
    zc_out_a: assert property ($past(!sys_rst) |-> cfg_r.zero_cross_comparator_off == $past(latch_zc_r))
        else $error("comparator output does not show latch");
    buck_out_a: assert property ($past(!sys_rst) |-> cfg_r.buck_only == $past(latch_buck_r))
        else $error("buck-only output does not show latch");
    zc_copy_a: assert property (!ctrl_r[`CCR_BIT_EN] |=> latch_zc_r == $past(ctrl_r[`CCR_BIT_ZC]))
        else $error("comparator latch did not copy while disabled");

    // value decoding
    vout_scale_a: assert property (vcode_r <= `CCR_OUTPUT_VOLTAGE_CODE_SAT |=> cfg_r.output_voltage_mv ==
                                   `CCR_VOUT_BASE_MV + 13'($past(vcode_r)) * `CCR_VOUT_STEP_MV)
        else $error("voltage code not on linear scale");
    ramp_bound_a: assert property (ramp_up |=> vsat(vcode_r) <= vsat($past(vf_r[5:0])))
        else $error("ramp passed its target");
    ipk_low_zero_a: assert property (ipk_r[3:0] == 4'h0 |=> cfg_r.peak_current_low_ma == 10'h000)
        else $error("low code zero not minimum on-time");
    ipk_top_half_a: assert property (ipk_r[3:0] == `CCR_IPK_TOP_CODE && switch_size_halving
                                     |=> cfg_r.peak_current_low_ma == `CCR_IPK_TOPH_MA)
        else $error("low code fifteen not halved top current");
    ipk_hi_top_a: assert property (ipk_r[7:4] == `CCR_IPK_TOP_CODE && !switch_size_halving
                                   |=> cfg_r.peak_current_high_ma == `CCR_IPK_TOP_MA)
        else $error("high code fifteen not top current");

endmodule

// ==== tb/ccr_host_model.sv ====
`timescale 1ns/1ps
module ccr_host_model
    import ccr_pkg::*;
(
    // clock
    input  wire logic mclk,
    // byte requests to the register bank
    output ccr_req_s  req
);
    initial req = '0;

    // one request per call; once released the strobes clear and addr and wdata turn to the inverse
    task automatic put(input logic [2:0] kind, input logic [7:0] val);
        @(posedge mclk);
        #1;
        req.addr_load = kind[2];
        req.wr        = kind[1];
        req.rd        = kind[0];
        req.addr      = val;
        req.wdata     = val;
        @(posedge mclk);
        #1;
        req.addr_load = 1'b0;
        req.wr        = 1'b0;
        req.rd        = 1'b0;
        req.addr      = ~val;
        req.wdata     = ~val;
    endtask

    task automatic set_ptr(input logic [7:0] a);
        put(3'h4, a);
    endtask

    task automatic wr_byte(input logic [7:0] d);
        put(3'h2, d);
    endtask

    task automatic rd_byte();
        put(3'h1, 8'h00);
    endtask
endmodule

// ==== tb/ccr_regs_tb_top.sv ====
`timescale 1ns/1ps
module ccr_regs_tb_top
    import ccr_pkg::*;
;
    logic       mclk;
    logic       sys_rst;
    logic       switch_size_halving;
    logic       sw_pulse_pin;
    ccr_req_s   req;
    logic       addr_ok_r;
    logic [7:0] rdata_r;
    ccr_cfg_s   cfg;
    int         miscompares;
    int         compares;
    logic [7:0] pk [4];
    int         rise_c [4];
    int         fall_c [4];

    initial mclk = 1'b0;
    always #2 mclk = ~mclk;

    ccr_host_model ccr_host_model_i (.mclk(mclk), .req(req));

    // short thresholds; ramp pacing kept at its real 50 us
    localparam logic [3:0][16:0] TB_RISE_CYC = {17'h14, 17'h1e, 17'h28, 17'h32};
    localparam logic [3:0][16:0] TB_FALL_CYC = {17'h3c, 17'h50, 17'h64, 17'h78};

    ccr_regs #(
        .RISE_CYC (TB_RISE_CYC),
        .FALL_CYC (TB_FALL_CYC)
    ) ccr_regs_i (
        .mclk                (mclk),
        .sys_rst             (sys_rst),
        .req                 (req),
        .addr_ok_r           (addr_ok_r),
        .rdata_r             (rdata_r),
        .switch_size_halving (switch_size_halving),
        .sw_pulse_pin        (sw_pulse_pin),
        .cfg_r               (cfg)
    );

    task automatic final_report();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        ccr_host_model_i.set_ptr(a);
        settle(2);
        chk("rdata", 16'(exp), 16'(rdata_r));
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        ccr_host_model_i.set_ptr(a);
        ccr_host_model_i.wr_byte(d);
        settle(3);
    endtask

    // two-cycle high pulses, one every period cycles
    task automatic pulses(input int period, input int n);
        repeat (n) begin
            sw_pulse_pin = 1'b1;
            settle(2);
            sw_pulse_pin = 1'b0;
            settle(period - 2);
        end
    endtask

    function automatic logic [15:0] pk_ma(input logic [3:0] c, input logic h, input logic low);
        if (low && c == 4'hf)
            return h ? 16'h177 : 16'h2ee;
        return 16'(c) * (h ? 16'h19 : 16'h32);
    endfunction

    initial begin
        repeat (60000) @(posedge mclk);
        miscompares++;
        final_report();
    end

    initial begin
        sys_rst = 1'b1;
        switch_size_halving = 1'b0;
        sw_pulse_pin = 1'b0;
        miscompares = 0;
        compares = 0;
        pk = '{8'h00, 8'h1e, 8'hf1, 8'hff};
        rise_c = '{50, 40, 30, 20};
        fall_c = '{120, 100, 80, 60};
        repeat (20) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        settle(3);
        chk("enable", 16'h1, 16'(cfg.output_enable));
        chk("fast", 16'h1, 16'(cfg.fast_response));
        chk("zc_off", 16'h1, 16'(cfg.zero_cross_comparator_off));
        chk("psv", 16'h0, 16'(cfg.passive_discharge_select));
        chk("fsel", 16'h3, 16'(cfg.freq_threshold_select));
        chk("vout_mv", 16'h1194, 16'(cfg.output_voltage_mv));
        chk("ipk_hi_ma", 16'h1f4, 16'(cfg.peak_current_high_ma));
        chk("ipk_lo_ma", 16'h190, 16'(cfg.peak_current_low_ma));
        chk("ramp_sel", 16'h1, 16'(cfg.voltage_ramp_select));
        chk("slow_edge", 16'h0, 16'(cfg.slow_edge_select));
        chk("buck", 16'h0, 16'(cfg.buck_only));
        chk("act", 16'h0, 16'(cfg.active_discharge_select));
        chk("vout_code", 16'h28, 16'(cfg.output_voltage_code));
        rd_chk(8'h01, 8'hf0);
        chk("addr_ok", 16'h1, 16'(addr_ok_r));
        ccr_host_model_i.rd_byte();
        settle(2);
        chk("rdata", 16'he8, 16'(rdata_r));
        ccr_host_model_i.rd_byte();
        settle(2);
        chk("rdata", 16'ha8, 16'(rdata_r));
        rd_chk(8'h05, 8'h00);
        chk("addr_ok", 16'h0, 16'(addr_ok_r));
        ccr_host_model_i.set_ptr(8'h00);
        ccr_host_model_i.wr_byte(8'h55);
        ccr_host_model_i.wr_byte(8'h55);
        settle(2);
        chk("addr_ok", 16'h0, 16'(addr_ok_r));
        // ramp is on from reset: one code per 50 us step, fall at once
        wr_reg(8'h02, 8'heb);
        chk("ramp_mid", 16'h1, 16'(cfg.output_voltage_code < 6'h2b));
        // at most two steps fit in two step periods, all three in three
        settle(24990);
        chk("ramp_slow", 16'h1, 16'(cfg.output_voltage_code < 6'h2b));
        settle(12550);
        chk("ramp_end", 16'h2b, 16'(cfg.output_voltage_code));
        wr_reg(8'h02, 8'he5);
        chk("ramp_down", 16'h25, 16'(cfg.output_voltage_code));
        ccr_host_model_i.set_ptr(8'h01);
        ccr_host_model_i.wr_byte(8'h84);
        ccr_host_model_i.wr_byte(8'hff);
        ccr_host_model_i.wr_byte(8'hf1);
        settle(3);
        chk("ramp_sel", 16'h0, 16'(cfg.voltage_ramp_select));
        chk("buck_held", 16'h0, 16'(cfg.buck_only));
        chk("zc_held", 16'h1, 16'(cfg.zero_cross_comparator_off));
        chk("vout_code", 16'h3f, 16'(cfg.output_voltage_code));
        chk("vout_mv", 16'h12c0, 16'(cfg.output_voltage_mv));
        rd_chk(8'h01, 8'h84);
        rd_chk(8'h02, 8'hff);
        rd_chk(8'h03, 8'hf1);
        for (int h = 0; h < 2; h++) begin
            switch_size_halving = h[0];
            foreach (pk[i]) begin
                wr_reg(8'h03, pk[i]);
                chk("ipk_hi", 16'(pk[i][7:4]), 16'(cfg.peak_current_code_high));
                chk("ipk_lo", 16'(pk[i][3:0]), 16'(cfg.peak_current_code_low));
                chk("ipk_hi_ma", pk_ma(pk[i][7:4], h[0], 1'b0), 16'(cfg.peak_current_high_ma));
                chk("ipk_lo_ma", pk_ma(pk[i][3:0], h[0], 1'b1), 16'(cfg.peak_current_low_ma));
            end
        end
        wr_reg(8'h01, 8'h07);
        chk("enable", 16'h0, 16'(cfg.output_enable));
        chk("buck", 16'h1, 16'(cfg.buck_only));
        chk("zc_off", 16'h0, 16'(cfg.zero_cross_comparator_off));
        chk("act", 16'h1, 16'(cfg.active_discharge_select));
        chk("psv", 16'h1, 16'(cfg.passive_discharge_select));
        wr_reg(8'h01, 8'h98);
        chk("buck_held", 16'h1, 16'(cfg.buck_only));
        chk("zc_held", 16'h0, 16'(cfg.zero_cross_comparator_off));
        chk("slow_edge", 16'h1, 16'(cfg.slow_edge_select));
        chk("act", 16'h0, 16'(cfg.active_discharge_select));
        for (int s = 0; s < 4; s++) begin
            wr_reg(8'h02, {s[1:0], 6'h28});
            chk("fsel", 16'(s[1:0]), 16'(cfg.freq_threshold_select));
            pulses(rise_c[s] + 8, 6);
            chk("keep_on", 16'h0, 16'(cfg.keep_blocks_on));
            pulses(rise_c[s] - 8, 6);
            chk("keep_on", 16'h1, 16'(cfg.keep_blocks_on));
            pulses(rise_c[s] + 8, 6);
            chk("keep_on", 16'h1, 16'(cfg.keep_blocks_on));
            settle(fall_c[s] + 20);
            chk("keep_on", 16'h0, 16'(cfg.keep_blocks_on));
        end
        final_report();
    end
endmodule
